// *** verilog/buf_cfg_consts.vh ***
// Constants for the message buffer configuration control block
`ifndef BUF_CFG_CONSTS_VH
`define BUF_CFG_CONSTS_VH
`define NUM_BUFS 59
`define BUF_IDX_W 6
`define ADDR_W 8
`define DATA_W 16
`define ADDR_MODE_CTRL 8'hf0
`define ADDR_INIT_MARKER 8'hf1
`define ADDR_FIFO_DEPTH 8'hf2
`define ADDR_STATUS 8'hf3
`define ADDR_BUF_SEL 8'hf4
`define ADDR_FRAME_ID 8'hf5
`define ADDR_BCS 8'hf6
`define ADDR_CYC_FILT 8'hf7
`define MODE_CFG_BIT 0
`define BCS_LOCK 0
`define BCS_IRQ_FLAG 1
`define BCS_VALID 2
`define BCS_IRQ_MASK 3
`define BCS_DIR 4
`define BCS_CHA 5
`define BCS_CHB 6
`define BCS_BTYPE 7
`define BCS_CYCLE_FILTER_ENABLE 8
`define BCS_TKIND 9
`define BCS_COMMIT 10
`define BCS_PUPD 11
`define BCS_CFG_MASK 16'h03f8
`define INIT_MARKER_DONE 16'h0001
`define FRAME_ID_W 11
`define CYC_FILT_W 12
`define ST_INIT 2'h0
`define ST_CONFIG 2'h1
`define ST_NORMAL 2'h2
`endif

// *** verilog/message_buffer_config_control.v ***
// Message buffer configuration control: config state, memory init, buffer map rules
`timescale 1ns/1ps
`include "buf_cfg_consts.vh"
module message_buffer_config_control (
	input wire clock_in,
	input wire rst_b_in,
	input wire [`ADDR_W-1:0] addr_in,
	input wire [`DATA_W-1:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output reg [`DATA_W-1:0] rdata_out,
	output wire config_state_out,
	output wire normal_state_out,
	output wire [`NUM_BUFS-1:0] buf_active_out,
	output wire [`NUM_BUFS-1:0] buf_is_fifo_out
);
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg cfg_req_reg;
	reg [`BUF_IDX_W-1:0] init_idx_reg;
	reg [`BUF_IDX_W-1:0] sel_reg;
	reg [`BUF_IDX_W-1:0] fifo_depth_reg;
	reg [`FRAME_ID_W-1:0] frame_id_mem [0:`NUM_BUFS-1];
	reg [`DATA_W-1:0] bcs_mem [0:`NUM_BUFS-1];
	reg [`CYC_FILT_W-1:0] cyc_mem [0:`NUM_BUFS-1];
	reg [`NUM_BUFS-1:0] cc_part_reg;
	reg [`NUM_BUFS-1:0] act_frame_reg;
	reg map_err_reg;
	integer i;

	// Buffer is controller part of a double transmit pair
	function is_cc_part;
		input [`BUF_IDX_W-1:0] idx;
		input [`DATA_W-1:0] prev_bcs;
		begin
			is_cc_part = (idx != 6'h00) && !idx[0] && prev_bcs[`BCS_BTYPE]
				&& prev_bcs[`BCS_DIR];
		end
	endfunction

	// Double request that breaks the map: receive, FIFO member, even host part, no partner
	function bad_double;
		input [`BUF_IDX_W-1:0] idx;
		input [`DATA_W-1:0] word;
		input in_fifo;
		begin
			bad_double = word[`BCS_BTYPE] && (!word[`BCS_DIR] || in_fifo || !idx[0]
				|| (idx >= (`NUM_BUFS - 1)));
		end
	endfunction

	function [`DATA_W-1:0] pad_frame;
		input [`FRAME_ID_W-1:0] f;
		begin
			pad_frame = {5'h00, f};
		end
	endfunction

	function [`DATA_W-1:0] pad_cyc;
		input [`CYC_FILT_W-1:0] c;
		begin
			pad_cyc = {4'h0, c};
		end
	endfunction

	function [`DATA_W-1:0] pad_idx;
		input [`BUF_IDX_W-1:0] v;
		begin
			pad_idx = {10'h000, v};
		end
	endfunction

	// Outside configuration the host may change only the interrupt mask and lock
	function [`DATA_W-1:0] run_bcs;
		input [`DATA_W-1:0] old;
		input [`DATA_W-1:0] word;
		begin
			run_bcs = {old[15:4], word[`BCS_IRQ_MASK], old[2:1], word[`BCS_LOCK]};
		end
	endfunction

	// Stored word in configuration: configuration bits, plus lock on the host buffer
	function [`DATA_W-1:0] cfg_bcs;
		input [`DATA_W-1:0] word;
		input with_lock;
		begin
			cfg_bcs = (word & `BCS_CFG_MASK) | {15'h0000, word[`BCS_LOCK] & with_lock};
		end
	endfunction

	wire in_init = (state_reg == `ST_INIT);
	wire in_cfg = (state_reg == `ST_CONFIG);
	wire sel_ok = (sel_reg < `NUM_BUFS);
	wire sel_cc = sel_ok && cc_part_reg[sel_reg];
	wire sel_fifo = sel_ok && (sel_reg < fifo_depth_reg);
	wire [`BUF_IDX_W-1:0] sel_pair = sel_reg + 6'h01;
	wire host_ok = !in_init;
	wire host_wr = wr_in && host_ok;
	wire wr_ok = host_wr && !sel_cc;
	wire [`DATA_W-1:0] sel_bcs = sel_ok ? bcs_mem[sel_reg] : 16'h0000;

	// Register map: f0 mode (bit 0 requests configuration), f1 init marker,
	// f2 FIFO depth, f3 status, f4 buffer select; f5 frame ID, f6 control/status
	// and f7 cycle filter act on the selected buffer
	wire hit_mode = (addr_in == `ADDR_MODE_CTRL);
	wire hit_fifo = (addr_in == `ADDR_FIFO_DEPTH);
	wire hit_sel = (addr_in == `ADDR_BUF_SEL);
	wire hit_frame = (addr_in == `ADDR_FRAME_ID);
	wire hit_bcs = (addr_in == `ADDR_BCS);
	wire hit_cyc = (addr_in == `ADDR_CYC_FILT);
	wire pair_ok = (sel_pair < `NUM_BUFS);
	wire pair_cc = pair_ok && cc_part_reg[sel_pair];
	wire dbl_bad = bad_double(sel_reg, wdata_in, sel_fifo);
	wire dbl_set = pair_ok && !dbl_bad && is_cc_part(sel_pair, wdata_in);
	wire leaving_cfg = in_cfg && (state_next == `ST_NORMAL);
	wire [`DATA_W-1:0] status_word = {12'h000, map_err_reg, normal_state_out, in_cfg, in_init};
	reg [`DATA_W-1:0] rdata_next;

	// Write enables; controller parts and init time refuse buffer writes
	wire cfg_wr = wr_ok && in_cfg && sel_ok;
	wire wr_mode = host_wr && hit_mode;
	wire wr_sel = host_wr && hit_sel;
	wire wr_fifo = host_wr && hit_fifo && in_cfg && (wdata_in[5:0] <= `NUM_BUFS);
	wire wr_bcs_cfg = cfg_wr && hit_bcs;
	wire wr_bcs_run = wr_ok && sel_ok && hit_bcs && !in_cfg;
	wire wr_cyc = cfg_wr && hit_cyc;
	wire wr_frame = cfg_wr && hit_frame && sel_bcs[`BCS_LOCK];

	assign config_state_out = in_cfg;
	assign normal_state_out = (state_reg == `ST_NORMAL);
	assign buf_active_out = normal_state_out ? act_frame_reg : {`NUM_BUFS{1'b0}};
	genvar g;
	generate
		for (g = 0; g < `NUM_BUFS; g = g + 1) begin : fifo_map
			assign buf_is_fifo_out[g] = (g < fifo_depth_reg);
		end
	endgenerate

	always @* begin
		state_next = state_reg;
		case (state_reg)
			`ST_INIT: begin
				if (init_idx_reg == `NUM_BUFS - 1)
					state_next = `ST_CONFIG;
			end
			`ST_CONFIG: begin
				if (!cfg_req_reg)
					state_next = `ST_NORMAL;
			end
			`ST_NORMAL: begin
				if (cfg_req_reg)
					state_next = `ST_CONFIG;
			end
			default: state_next = `ST_INIT;
		endcase
	end

	// State register and the configuration request bit
	always @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_reg <= `ST_INIT;
			cfg_req_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			if (wr_mode)
				cfg_req_reg <= wdata_in[`MODE_CFG_BIT];
		end
	end

	// Init sweep: one buffer cleared per clock from the first edge after reset
	always @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in)
			init_idx_reg <= 6'h00;
		else if (in_init)
			init_idx_reg <= init_idx_reg + 6'h01;
	end

	// Buffer select and FIFO depth; depth beyond the buffer count is refused
	always @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sel_reg <= 6'h00;
			fifo_depth_reg <= 6'h00;
		end else begin
			if (wr_sel)
				sel_reg <= wdata_in[5:0];
			if (wr_fifo)
				fifo_depth_reg <= wdata_in[5:0];
		end
	end

	// Double pair map and the sticky map error flag
	always @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cc_part_reg <= {`NUM_BUFS{1'b0}};
			map_err_reg <= 1'b0;
		end else if (wr_bcs_cfg) begin
			if (dbl_bad)
				map_err_reg <= 1'b1;
			else if (sel_reg[0] && pair_ok)
				cc_part_reg[sel_pair] <= is_cc_part(sel_pair, wdata_in);
		end
	end

	// Frame IDs are sampled once, as configuration is left
	always @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			act_frame_reg <= {`NUM_BUFS{1'b0}};
		end else if (leaving_cfg) begin
			for (i = 0; i < `NUM_BUFS; i = i + 1)
				act_frame_reg[i] <= (frame_id_mem[i] != 11'h000);
		end
	end

	// Read mux; the registered word stands only in the cycle after the strobe
	always @* begin
		rdata_next = 16'h0000;
		if (rd_in) begin
			case (addr_in)
				`ADDR_INIT_MARKER: rdata_next = in_init ? 16'h0000 : `INIT_MARKER_DONE;
				`ADDR_MODE_CTRL: rdata_next = host_ok ? {15'h0000, cfg_req_reg} : 16'h0000;
				`ADDR_FIFO_DEPTH: rdata_next = host_ok ? pad_idx(fifo_depth_reg) : 16'h0000;
				`ADDR_STATUS: rdata_next = status_word;
				`ADDR_BUF_SEL: rdata_next = pad_idx(sel_reg);
				`ADDR_FRAME_ID: rdata_next = (host_ok && sel_ok && !sel_cc) ?
					pad_frame(frame_id_mem[sel_reg]) : 16'h0000;
				`ADDR_BCS: rdata_next = host_ok ? sel_bcs : 16'h0000;
				`ADDR_CYC_FILT: rdata_next = (host_ok && sel_ok) ?
					pad_cyc(cyc_mem[sel_reg]) : 16'h0000;
				default: rdata_next = 16'h0000;
			endcase
		end
	end

	always @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in)
			rdata_out <= 16'h0000;
		else
			rdata_out <= rdata_next;
	end

	// Buffer memory: cleared by the init sweep, host writes, pair mirroring
	always @(posedge clock_in) begin
		if (in_init) begin
			frame_id_mem[init_idx_reg] <= 11'h000;
			bcs_mem[init_idx_reg] <= 16'h0000;
			cyc_mem[init_idx_reg] <= 12'h000;
		end else begin
			if (wr_bcs_cfg) begin
				bcs_mem[sel_reg] <= cfg_bcs(wdata_in, 1'b1);
				// A legal double also configures its controller part
				if (dbl_set) begin
					bcs_mem[sel_pair] <= cfg_bcs(wdata_in, 1'b0);
					cyc_mem[sel_pair] <= cyc_mem[sel_reg];
				end
			end else if (wr_bcs_run) begin
				bcs_mem[sel_reg] <= run_bcs(sel_bcs, wdata_in);
			end
			if (wr_cyc) begin
				cyc_mem[sel_reg] <= wdata_in[11:0];
				if (pair_cc)
					cyc_mem[sel_pair] <= wdata_in[11:0];
			end
			// The frame ID needs the buffer locked first
			if (wr_frame) begin
				frame_id_mem[sel_reg] <= wdata_in[10:0];
				if (pair_cc)
					frame_id_mem[sel_pair] <= wdata_in[10:0];
			end
		end
	end
endmodule

// *** test/host_model.sv ***
// Host bus model: one register access per call
`timescale 1ns/1ps
module host_model (
	input wire clock_in,
	input wire [15:0] rdata_in,
	output reg [7:0] addr_out = 8'h00,
	output reg [15:0] wdata_out = 16'h0000,
	output reg wr_out = 1'b0,
	output reg rd_out = 1'b0
);
	task acc(input w, input [7:0] a, input [15:0] d, output [15:0] q);
		@(posedge clock_in);
		{wr_out, rd_out, addr_out, wdata_out} <= {w, !w, a, d};
		@(posedge clock_in) {wr_out, rd_out} <= 2'b00;
		#1 q = rdata_in;
	endtask
endmodule

// *** test/buf_cfg_props.sv ***
// Port checks for buffer configuration control
`timescale 1ns/1ps
module buf_cfg_props (
	input wire clock_in,
	input wire rst_b_in,
	input wire [7:0] addr_in,
	input wire [15:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	input wire [15:0] rdata_out,
	input wire config_state_out,
	input wire normal_state_out,
	input wire [58:0] buf_active_out,
	input wire [58:0] buf_is_fifo_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_mw; wr_in && addr_in == 8'hf0; endsequence
	property p_mk; rd_in && addr_in == 8'hf1 && config_state_out |=> rdata_out == 16'h1; endproperty
	property p_off; !normal_state_out |-> buf_active_out == 59'h0; endproperty
	property p_ini; $rose(rst_b_in) |-> !config_state_out [*8]; endproperty
	property p_up; $rose(rst_b_in) |-> ##[50:70] config_state_out; endproperty
	property p_ex; s_mw ##0 (!wdata_in[0] && config_state_out) |-> ##[1:3] normal_state_out; endproperty
	property p_en; s_mw ##0 (wdata_in[0] && normal_state_out) |-> ##[1:3] config_state_out; endproperty
	property p_fz; normal_state_out && $past(normal_state_out) |-> $stable(buf_active_out); endproperty
	property p_ff; ((buf_is_fifo_out + 59'h1) & buf_is_fifo_out) == 59'h0; endproperty
	a_mk: assert property (p_mk) else $error("marker");
	a_off: assert property (p_off) else $error("active");
	a_ini: assert property (p_ini) else $error("early");
	a_up: assert property (p_up) else $error("no config");
	a_ex: assert property (p_ex) else $error("no exit");
	a_en: assert property (p_en) else $error("no entry");
	a_fz: assert property (p_fz) else $error("map moved");
	a_ff: assert property (p_ff) else $error("fifo run");
endmodule
bind message_buffer_config_control buf_cfg_props u_props (.clock_in(clock_in),
	.rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
	.rdata_out(rdata_out), .config_state_out(config_state_out),
	.normal_state_out(normal_state_out), .buf_active_out(buf_active_out),
	.buf_is_fifo_out(buf_is_fifo_out));

// *** test/tb.sv ***
// Self-checking bench for buffer configuration control
`timescale 1ns/1ps
module tb;
	reg clock_in = 1'b0, rst_b_in = 1'b0;
	integer fails = 0, checks = 0, cyc = 0;
	reg [31:0] seed = 32'h12;
	reg [15:0] v, n;
	reg [58:0] em;
	integer k;
	wire [7:0] addr_in;
	wire [15:0] wdata_in, rdata_out;
	wire wr_in, rd_in, config_state_out, normal_state_out;
	wire [58:0] buf_active_out, buf_is_fifo_out;
	host_model u_host_model (.clock_in(clock_in), .rdata_in(rdata_out), .addr_out(addr_in),
		.wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));
	message_buffer_config_control u_message_buffer_config_control (.clock_in(clock_in),
		.rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out), .config_state_out(config_state_out),
		.normal_state_out(normal_state_out), .buf_active_out(buf_active_out),
		.buf_is_fifo_out(buf_is_fifo_out));
	initial forever #20 clock_in = ~clock_in;
	function [31:0] xs(input [31:0] s);
		xs = s ^ (s << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	function [58:0] fmap(input [15:0] k); fmap = (59'h1 << k) - 59'h1; endfunction
	task h(input w, input [7:0] a, input [15:0] d); u_host_model.acc(w, a, d, v); endtask
	task chk(input [63:0] nm, input [58:0] e, input [58:0] g);
		checks = checks + 1;
		fails = fails + (g !== e);
		if (g !== e) $display("[ERR] %0s exp %h got %h", nm, e, g);
	endtask
	task test_done(input integer x);
		$display("checks %0d fails %0d", checks, fails + x);
		if (fails + x == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clock_in) cyc <= cyc + 1;
	always @(posedge clock_in) if (cyc == 2000) test_done(1);
	initial begin
		repeat (10) @(posedge clock_in);
		rst_b_in <= 1'b1;
		h(1'b0, 8'hf1, 16'h0);
		chk("busy", 59'h0, {43'h0, v});
		repeat (40) if (v !== 16'h1) h(1'b0, 8'hf1, 16'h0);
		chk("marker", 59'h1, {43'h0, v});
		chk("config", 59'h1, {58'h0, config_state_out});
		h(1'b1, 8'hf4, 16'h14);
		h(1'b0, 8'hf6, 16'h0);
		n = v;
		h(1'b0, 8'hf7, 16'h0);
		n = n | v;
		h(1'b0, 8'hf5, 16'h0);
		chk("cleared", 59'h0, {43'h0, n | v});
		$display("init test done");
		seed = xs(seed);
		n = {14'h0, seed[1:0]} + 16'h1;
		h(1'b1, 8'hf2, n);
		chk("fifo", fmap(n), buf_is_fifo_out);
		h(1'b1, 8'hf4, 16'h7);
		h(1'b1, 8'hf6, 16'hb0);
		h(1'b1, 8'hf7, 16'h123);
		h(1'b1, 8'hf6, 16'hb1);
		h(1'b0, 8'hf6, 16'h0);
		chk("lock", 59'h1, {58'h0, v[0]});
		h(1'b1, 8'hf5, 16'h5);
		h(1'b1, 8'hf6, 16'hb0);
		h(1'b1, 8'hf4, 16'h8);
		h(1'b1, 8'hf6, 16'h1);
		h(1'b0, 8'hf6, 16'h0);
		chk("cc_part", 59'hb0, {43'h0, v & 16'h3f9});
		h(1'b0, 8'hf7, 16'h0);
		chk("cc_cyc", 59'h123, {43'h0, v});
		h(1'b1, 8'hf4, 16'hb);
		h(1'b1, 8'hf6, 16'h80);
		h(1'b0, 8'hf3, 16'h0);
		chk("map_err", 59'h1, {58'h0, v[3]});
		em = 59'h180;
		repeat (3) begin
			seed = xs(seed);
			k = 20 + seed[2:0];
			em[k] = 1'b1;
			h(1'b1, 8'hf4, k[15:0]);
			h(1'b1, 8'hf6, 16'h20);
			h(1'b1, 8'hf7, 16'h0);
			h(1'b1, 8'hf6, 16'h21);
			h(1'b1, 8'hf5, {5'h0, seed[18:8] | 11'h1});
			h(1'b1, 8'hf6, 16'h20);
		end
		$display("map test done");
		h(1'b1, 8'hf0, 16'h0);
		repeat (3) @(negedge clock_in);
		chk("normal", 59'h1, {58'h0, normal_state_out});
		chk("active", em, buf_active_out);
		h(1'b1, 8'hf2, 16'h9);
		h(1'b0, 8'hf2, 16'h0);
		chk("fifokeep", {43'h0, n}, {43'h0, v});
		$display("normal test done");
		h(1'b1, 8'hf0, 16'h1);
		repeat (2) @(negedge clock_in);
		chk("reenter", 59'h1, {58'h0, config_state_out});
		chk("inactive", 59'h0, buf_active_out);
		$display("config test done");
		test_done(0);
	end
endmodule
